// ### pkg/aspc_cfg.svh
// Constants of the accelerometer signal-path control block.
// Assumes a 40 ns system clock and byte-wide register access.
`ifndef ASPC_CFG_SVH
`define ASPC_CFG_SVH

// Register offsets on the register port
`define ASPC_ADDR_W        10
`define ASPC_FILTER_OFS    10'h028
`define ASPC_SELFTEST_OFS  10'h02E

// Filter register fields
`define ASPC_FILTER_RST    8'h00
`define ASPC_FILTER_MASK   8'h7F
`define ASPC_ODR_LSB       0
`define ASPC_ODR_W         4
`define ASPC_ODR_MAX       4'hA
`define ASPC_HPC_LSB       4
`define ASPC_HPC_W         3

// Self-test register fields
`define ASPC_ST_RST        8'h00
`define ASPC_ST_MASK       8'h03
`define ASPC_ST_EN_BIT     0
`define ASPC_ST_FORCE_BIT  1

// Overrange thresholds in g: 40 g in the smallest range, 80 g otherwise
`define ASPC_THR_SMALL_G   8'h28
`define ASPC_THR_LARGE_G   8'h50
`define ASPC_RANGE_SMALL   2'h0

// Timing
`define ASPC_CLK_NS        40
`define ASPC_OVR_HOLD_NS   500000
`define ASPC_OVR_HOLD_CYC  ((`ASPC_OVR_HOLD_NS + `ASPC_CLK_NS - 1) / `ASPC_CLK_NS)

// Datapath
`define ASPC_ADC_W         20
`define ASPC_DEC1_LOG2     6
`define ASPC_DRIFT_SHIFT   3
`define ASPC_HPF_FRAC      12
`define ASPC_WORD_W        22

`endif

// ### pkg/aspc_pkg.sv
// Types of the accelerometer signal-path control block.
// Assumes aspc_cfg.svh for the output word width.
`default_nettype none
`include "aspc_cfg.svh"

package aspc_pkg;

  typedef logic [1:0]               aspc_axis_t;
  typedef logic [2:0][31:0]         aspc_vec3_t;

  typedef struct packed {
    logic [7:0]                     filter;
    logic [7:0]                     st;
    logic [7:0]                     rdata;
    logic                           drive_en;
    logic [23:0]                    hold;
    logic [31:0]                    now;
    aspc_vec3_t                     acc1;
    aspc_vec3_t                     acc2;
    logic [2:0][11:0]               cnt1;
    logic [2:0][9:0]                cnt2;
    aspc_vec3_t                     lp;
    aspc_vec3_t                     last;
    aspc_vec3_t                     out;
    aspc_vec3_t                     step;
    aspc_vec3_t                     stamp;
    logic                           pend;
    logic [`ASPC_WORD_W-1:0]        pend_word;
    logic [31:0]                    pend_stamp;
    logic                           adc_ready;
    logic                           st_stim;
    logic [31:0]                    gd;
  } aspc_state_s;

endpackage

`default_nettype wire

// ### pkg/aspc_stream_if.sv
// Valid/ready word stream between the signal path and its output buffer.
// Assumes both ends share one clock.
`default_nettype none

interface aspc_stream_if #(
  parameter int unsigned W = 22
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

`default_nettype wire

// ### hdl/aspc_buf2.sv
// Two-entry output buffer: an output register plus one skid entry.
// Assumes one clock, asynchronous active-low reset.
`default_nettype none

module aspc_buf2 #(
  parameter int unsigned W     = 22,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // Filling side
  aspc_stream_if.dst    in_s,
  // Draining side
  output logic          out_valid,
  input  wire logic     out_ready,
  output logic [W-1:0]  out_data
);

  if (DEPTH != 2) begin : g_chk
    $error("aspc_buf2 holds exactly two entries");
  end

  typedef struct packed {
    logic         out_valid;
    logic [W-1:0] out_data;
    logic         skid_valid;
    logic [W-1:0] skid_data;
  } aspc_buf_state_s;

  aspc_buf_state_s s_r;
  aspc_buf_state_s s_nxt;

  // Ready comes straight from a flop, so the source never sees a loop
  assign in_s.ready = ~s_r.skid_valid;
  assign out_valid  = s_r.out_valid;
  assign out_data   = s_r.out_data;

  always_comb begin
    logic pop;
    logic push;
    pop   = s_r.out_valid & out_ready;
    push  = in_s.valid & ~s_r.skid_valid;
    s_nxt = s_r;
    if (pop) begin
      s_nxt.out_valid = 1'b0;
    end
    if (s_r.skid_valid && (!s_r.out_valid || pop)) begin
      s_nxt.out_valid  = 1'b1;
      s_nxt.out_data   = s_r.skid_data;
      s_nxt.skid_valid = 1'b0;
    end
    if (push) begin
      if (!s_nxt.out_valid) begin
        s_nxt.out_valid = 1'b1;
        s_nxt.out_data  = in_s.data;
      end else begin
        s_nxt.skid_valid = 1'b1;
        s_nxt.skid_data  = in_s.data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// ### hdl/aspc_signal_path.sv
// Digital signal path control of a three-axis accelerometer: overrange
// protection, self-test stimulus, two-stage decimation, high-pass filter,
// interpolation and a two-entry output buffer.
// Assumes converter samples arrive tagged by axis, synchronous to clk.
// Behaviour
// - Overrange stops all sensor drive clocks for 0.5 ms.
// - Threshold is 40 g in the smallest range, 80 g in larger ranges.
// - During protection output drifts to zero and buffer keeps accepting it.
// - Stimulus applied only when self-test enable and force are both one.
// - Each axis is digitised as a 20-bit converter sample.
// - Output sample rates run from 4 kHz down to 3.906 Hz.
// - First decimation stage always produces the 4 kHz rate.
// - Second decimation stage serves 2 kHz and below, bypassed at 4 kHz.
// - High-pass filter is off after reset until software programs it.
// - High-pass corner follows output rate and corner field bits 6 to 4 at 0x28.
// - Interpolation after decimation upconverts and offers external sync.
// - Group delay is measured from converter input to hand-over of the word into the output buffer.
// - Reset defaults: high-pass off, 4000 Hz output rate.
`default_nettype none
`include "aspc_cfg.svh"

module aspc_signal_path #(
  parameter int unsigned DEC1_LOG2    = `ASPC_DEC1_LOG2,
  parameter int unsigned OVR_HOLD_CYC = `ASPC_OVR_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Register port
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [`ASPC_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic [7:0]                     reg_rdata_r,
  // Converter samples
  input  wire logic                      adc_valid,
  input  wire logic [1:0]                adc_axis,
  input  wire logic [`ASPC_ADC_W-1:0]    adc_data,
  output logic                           adc_ready_r,
  // Sensor front end
  input  wire logic [1:0]                range_sel,
  input  wire logic [7:0]                accel_mag_g,
  output logic                           drive_clk_en_r,
  output logic                           self_test_stim_r,
  // External synchronisation
  input  wire logic                      ext_sync,
  // Filtered samples
  output logic                           smp_valid_r,
  input  wire logic                      smp_ready,
  output logic [`ASPC_WORD_W-1:0]        smp_data_r,
  output logic [31:0]                    group_delay_r
);

  if (DEC1_LOG2 < 1 || DEC1_LOG2 > 11) begin : g_chk_dec
    $error("DEC1_LOG2 must lie in 1..11");
  end
  if (OVR_HOLD_CYC < 1 || OVR_HOLD_CYC > 24'hFFFFFF) begin : g_chk_hold
    $error("OVR_HOLD_CYC must fit 24 bits");
  end

  localparam logic [11:0] DEC1_LAST = 12'((1 << DEC1_LOG2) - 1);
  localparam logic [23:0] HOLD_LAST = 24'(OVR_HOLD_CYC - 1);

  aspc_pkg::aspc_state_s s_r;
  aspc_pkg::aspc_state_s s_nxt;

  aspc_stream_if #(.W(`ASPC_WORD_W)) buf_in ();

  assign buf_in.valid     = s_r.pend;
  assign buf_in.data      = s_r.pend_word;
  assign reg_rdata_r      = s_r.rdata;
  assign adc_ready_r      = s_r.adc_ready;
  assign drive_clk_en_r   = s_r.drive_en;
  assign self_test_stim_r = s_r.st_stim;
  assign group_delay_r    = s_r.gd;

  always_comb begin
    logic [1:0]        ax;
    logic [3:0]        output_sample_rate;
    logic [2:0]        hpc;
    logic [7:0]        thr;
    logic [9:0]        cnt2_last;
    logic signed [31:0] x1;
    logic signed [31:0] a1;
    logic signed [31:0] a2;
    logic signed [31:0] s1;
    logic signed [31:0] s2;
    logic signed [31:0] xq;
    logic signed [31:0] lpn;
    logic signed [31:0] hp;
    logic signed [31:0] o;
    logic              fire2;
    ax        = adc_axis;
    output_sample_rate       = s_r.filter[`ASPC_ODR_LSB +: `ASPC_ODR_W];
    hpc       = s_r.filter[`ASPC_HPC_LSB +: `ASPC_HPC_W];
    thr       = `ASPC_THR_LARGE_G;
    cnt2_last = 10'h000;
    x1        = {{(32-`ASPC_ADC_W){adc_data[`ASPC_ADC_W-1]}}, adc_data};
    a1        = 32'sh0;
    a2        = 32'sh0;
    s1        = 32'sh0;
    s2        = 32'sh0;
    xq        = 32'sh0;
    lpn       = 32'sh0;
    hp        = 32'sh0;
    o         = 32'sh0;
    fire2     = 1'b0;
    s_nxt     = s_r;
    s_nxt.now = s_r.now + 32'h00000001;

    // Rates beyond the slowest are clamped to 3.906 Hz
    if (output_sample_rate > `ASPC_ODR_MAX) begin
      output_sample_rate = `ASPC_ODR_MAX;
    end
    cnt2_last = (10'h001 << output_sample_rate) - 10'h001;

    // Register writes; reserved bits are kept at zero
    if (reg_wr) begin
      if (reg_addr == `ASPC_FILTER_OFS) begin
        s_nxt.filter = reg_wdata & `ASPC_FILTER_MASK;
      end else if (reg_addr == `ASPC_SELFTEST_OFS) begin
        s_nxt.st = reg_wdata & `ASPC_ST_MASK;
      end
    end
    if (reg_rd) begin
      if (reg_addr == `ASPC_FILTER_OFS) begin
        s_nxt.rdata = s_r.filter;
      end else if (reg_addr == `ASPC_SELFTEST_OFS) begin
        s_nxt.rdata = s_r.st;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end
    s_nxt.st_stim = s_nxt.st[`ASPC_ST_EN_BIT] & s_nxt.st[`ASPC_ST_FORCE_BIT];

    // Overrange: a renewed trip restarts the full hold time
    if (range_sel == `ASPC_RANGE_SMALL) begin
      thr = `ASPC_THR_SMALL_G;
    end
    if (accel_mag_g >= thr) begin
      s_nxt.drive_en = 1'b0;
      s_nxt.hold     = HOLD_LAST;
    end else if (s_r.hold != 24'h000000) begin
      s_nxt.hold = s_r.hold - 24'h000001;
    end else begin
      s_nxt.drive_en = 1'b1;
    end

    // Word handed to the buffer; delay measured at that moment
    if (s_r.pend && buf_in.ready) begin
      s_nxt.pend = 1'b0;
      s_nxt.gd   = s_r.now - s_r.pend_stamp;
    end

    // External sync realigns the second-stage phase of every axis
    if (ext_sync) begin
      s_nxt.cnt2 = '0;
      s_nxt.acc2 = '0;
    end

    if (adc_valid && s_r.adc_ready) begin
      a1 = $signed(s_r.acc1[ax]) + x1;
      s_nxt.acc1[ax] = a1;
      s_nxt.cnt1[ax] = s_r.cnt1[ax] + 12'h001;
      if (s_r.cnt1[ax] == 12'h000) begin
        s_nxt.stamp[ax] = s_r.now;
      end
      if (s_r.cnt1[ax] == DEC1_LAST) begin
        // First stage: fixed decimation to 4 kHz
        s1 = a1 >>> DEC1_LOG2;
        s_nxt.acc1[ax] = 32'h00000000;
        s_nxt.cnt1[ax] = 12'h000;
        if (output_sample_rate == 4'h0) begin
          fire2 = 1'b1;
          s2    = s1;
        end else begin
          a2 = (ext_sync ? 32'sh0 : $signed(s_r.acc2[ax])) + s1;
          s_nxt.acc2[ax] = a2;
          s_nxt.cnt2[ax] = (ext_sync ? 10'h000 : s_r.cnt2[ax]) + 10'h001;
          if ((ext_sync ? 10'h000 : s_r.cnt2[ax]) == cnt2_last) begin
            fire2 = 1'b1;
            s2    = a2 >>> output_sample_rate;
            s_nxt.acc2[ax] = 32'h00000000;
            s_nxt.cnt2[ax] = 10'h000;
          end
        end
        if (fire2) begin
          // Single-pole high-pass; a zero corner field passes DC
          xq  = s2 <<< `ASPC_HPF_FRAC;
          lpn = $signed(s_r.lp[ax]);
          if (hpc != 3'h0) begin
            lpn = lpn + ((xq - lpn) >>> hpc);
          end
          s_nxt.lp[ax] = lpn;
          hp = (hpc == 3'h0) ? s2 : s2 - (lpn >>> `ASPC_HPF_FRAC);
          // Interpolation ramps from the previous sample to this one
          s_nxt.step[ax] = (hp - $signed(s_r.last[ax])) >>> output_sample_rate;
          s_nxt.last[ax] = hp;
          o = $signed(s_r.last[ax]);
        end else begin
          o = $signed(s_r.out[ax]) + $signed(s_r.step[ax]);
        end
        // Protection: output decays toward zero yet is still delivered
        if (!s_r.drive_en) begin
          o = $signed(s_r.out[ax]) - ($signed(s_r.out[ax]) >>> `ASPC_DRIFT_SHIFT);
        end
        s_nxt.out[ax]    = o;
        s_nxt.pend       = 1'b1;
        s_nxt.pend_word  = {ax, o[`ASPC_ADC_W-1:0]};
        s_nxt.pend_stamp = s_r.stamp[ax];
      end
    end

    // Sample intake stalls while a word still waits for the buffer
    s_nxt.adc_ready = ~s_nxt.pend;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r           <= '0;
      s_r.filter    <= `ASPC_FILTER_RST;
      s_r.st        <= `ASPC_ST_RST;
      s_r.drive_en  <= 1'b1;
      s_r.adc_ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  aspc_buf2 #(
    .W     (`ASPC_WORD_W),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_s      (buf_in),
    .out_valid (smp_valid_r),
    .out_ready (smp_ready),
    .out_data  (smp_data_r)
  );

endmodule

`default_nettype wire

// ### tb/aspc_signal_path_asserts.sv
// Port checks of the accelerometer signal path top.
// Assumes it is bound into aspc_signal_path; one clock domain.
`default_nettype none
`include "aspc_cfg.svh"
module aspc_signal_path_asserts #(
  parameter int unsigned OVR_HOLD_CYC = `ASPC_OVR_HOLD_CYC
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // Register port
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [`ASPC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic [7:0]              reg_rdata_r,
  // Front end
  input wire logic                    adc_ready_r,
  input wire logic [1:0]              range_sel,
  input wire logic [7:0]              accel_mag_g,
  input wire logic                    drive_clk_en_r,
  input wire logic                    self_test_stim_r,
  // Output stream
  input wire logic                    smp_valid_r,
  input wire logic                    smp_ready,
  input wire logic [`ASPC_WORD_W-1:0] smp_data_r,
  input wire logic [31:0]             group_delay_r
);
  logic        over;
  logic [15:0] since_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign over = accel_mag_g >= ((range_sel == 2'h0) ? 8'h28 : 8'h50);
  // Edges since the last over-threshold edge; saturates so a long run never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      since_r <= 16'h0;
    else if (over)
      since_r <= 16'h1;
    else if (since_r != 16'h0 && since_r != 16'hFFFF)
      since_r <= since_r + 16'h1;
  end
  property p_ovr_hold;
    since_r >= 16'h1 && since_r <= 16'(OVR_HOLD_CYC) |-> !drive_clk_en_r;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("drive clocks ran in hold");
  property p_ovr_end;
    since_r == 16'h0 || since_r > 16'(OVR_HOLD_CYC + 1) |-> drive_clk_en_r;
  endproperty
  a_ovr_end: assert property (p_ovr_end) else $error("drive clocks stopped");
  property p_st_stim;
    reg_wr && reg_addr == 10'h02E |=> self_test_stim_r == ($past(reg_wdata[0]) && $past(reg_wdata[1]));
  endproperty
  a_st_stim: assert property (p_st_stim) else $error("stimulus wrong");
  property p_st_rb;
    reg_wr && reg_addr == 10'h02E ##1 reg_rd && !reg_wr && reg_addr == 10'h02E
      |=> reg_rdata_r == ($past(reg_wdata, 2) & 8'h03);
  endproperty
  a_st_rb: assert property (p_st_rb) else $error("self test readback");
  property p_flt_rb;
    reg_wr && reg_addr == 10'h028 ##1 reg_rd && !reg_wr && reg_addr == 10'h028
      |=> reg_rdata_r == ($past(reg_wdata, 2) & 8'h7F);
  endproperty
  a_flt_rb: assert property (p_flt_rb) else $error("filter readback");
  property p_smp_hold;
    smp_valid_r && !smp_ready |=> smp_valid_r && $stable(smp_data_r);
  endproperty
  a_smp_hold: assert property (p_smp_hold) else $error("word lost in stall");
  property p_stall;
    !adc_ready_r && smp_ready |-> ##[1:4] adc_ready_r;
  endproperty
  a_stall: assert property (p_stall) else $error("intake stuck");
  property p_gd;
    $changed(group_delay_r) |-> smp_valid_r;
  endproperty
  a_gd: assert property (p_gd) else $error("delay moved without a word");
endmodule
`default_nettype wire

// ### tb/aspc_host_model.sv
// Host that reads filtered words from the output stream.
// Assumes the bench sets stall to slow it to one word in four cycles.
`default_nettype none
module aspc_host_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Sample stream
  input  wire logic        smp_valid_r,
  input  wire logic [21:0] smp_data_r,
  output logic             smp_ready,
  // Bench side
  input  wire logic        stall,
  output logic [21:0]      last_w,
  output logic [15:0]      cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  // A slow host backs the buffer up so back-pressure is exercised
  always @(negedge clk) begin
    ph = ph + 2'h1;
    smp_ready = rst_n && (!stall || ph == 2'h0);
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0;
      last_w <= 22'h0;
    end else if (smp_valid_r && smp_ready) begin
      cnt <= cnt + 16'h1;
      last_w <= smp_data_r;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the accelerometer signal path.
// Assumes a shortened overrange hold and four samples per first stage.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t: got %0h want %0h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HOLD = 20;
  localparam logic [19:0] V = 20'h00800;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [9:0]  reg_addr = 10'h000;
  logic [7:0]  reg_wdata = 8'h00, accel_mag_g = 8'h00, reg_rdata_r, rv;
  logic        adc_valid = 1'b0, adc_ready_r, drive_clk_en_r, self_test_stim_r;
  logic [1:0]  adc_axis = 2'h0, range_sel = 2'h0;
  logic [19:0] adc_data = 20'h00000;
  logic        smp_valid_r, smp_ready, stall = 1'b0, ext_sync = 1'b0;
  logic [21:0] smp_data_r, last_w;
  logic [31:0] group_delay_r;
  logic [15:0] cnt;
  int          error_cnt = 0, comparisons = 0, cyc = 0, expw = 0;
  aspc_signal_path #(.DEC1_LOG2(2), .OVR_HOLD_CYC(HOLD)) aspc_signal_path_inst (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .adc_valid(adc_valid), .adc_axis(adc_axis),
    .adc_data(adc_data), .adc_ready_r(adc_ready_r), .range_sel(range_sel), .accel_mag_g(accel_mag_g),
    .drive_clk_en_r(drive_clk_en_r), .self_test_stim_r(self_test_stim_r), .ext_sync(ext_sync),
    .smp_valid_r(smp_valid_r), .smp_ready(smp_ready), .smp_data_r(smp_data_r), .group_delay_r(group_delay_r));
  aspc_host_model aspc_host_model_inst (.clk(clk), .rst_n(rst_n), .smp_valid_r(smp_valid_r),
    .smp_data_r(smp_data_r), .smp_ready(smp_ready), .stall(stall), .last_w(last_w), .cnt(cnt));
  always #20 clk = ~clk;
  task automatic print_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    rv = reg_rdata_r;
  endtask
  task automatic send(input logic [1:0] ax, input logic [19:0] v, input int n);
    logic r;
    adc_valid = 1'b1;
    adc_axis = ax;
    adc_data = v;
    while (n > 0) begin
      r = adc_ready_r;
      @(negedge clk);
      if (r)
        n--;
    end
    adc_valid = 1'b0;
  endtask
  task automatic wait_words(input int k);
    expw += k;
    for (int i = 0; i < 300 && int'(cnt) < expw; i++)
      @(negedge clk);
    `CHK(int'(cnt), expw)
  endtask
  task automatic t_regs;
    logic [7:0] seq[4] = '{8'h01, 8'h03, 8'hFF, 8'h00};
    `CHK(drive_clk_en_r, 1'b1)
    rd(10'h028);
    `CHK(rv, 8'h00)
    foreach (seq[i]) begin
      wr(10'h02E, seq[i]);
      `CHK(self_test_stim_r, seq[i][0] & seq[i][1])
      rd(10'h02E);
      `CHK(rv, seq[i] & 8'h03)
    end
    wr(10'h028, 8'hFF);
    rd(10'h028);
    `CHK(rv, 8'h7F)
    @(negedge clk);
    rd(10'h3FF);
    `CHK(rv, 8'h00)
    wr(10'h028, 8'h00);
  endtask
  task automatic t_stream;
    stall = 1'b1;
    send(2'h0, V, 12);
    @(negedge clk);
    send(2'h1, 20'hFF000, 12);
    wait_words(6);
    `CHK(last_w, {2'h1, 20'hFF000})
    stall = 1'b0;
  endtask
  task automatic t_hpf;
    wr(10'h028, 8'h10);
    send(2'h0, V, 24);
    wait_words(6);
    `CHK(last_w[19:0] < V, 1'b1)
    wr(10'h028, 8'h00);
  endtask
  task automatic t_odr;
    @(negedge clk);
    wr(10'h028, 8'h01);
    send(2'h2, V, 16);
    wait_words(4);
    `CHK(last_w[21:20], 2'h2)
    wr(10'h028, 8'h0A);
    send(2'h2, V, 8);
    wait_words(2);
    wr(10'h028, 8'h00);
  endtask
  task automatic t_ovr(input logic [1:0] rs, input logic [7:0] thr);
    range_sel = rs;
    send(2'h0, V, 12);
    wait_words(3);
    `CHK(last_w, {2'h0, V})
    accel_mag_g = thr - 8'h01;
    repeat (3) @(negedge clk);
    `CHK(drive_clk_en_r, 1'b1)
    accel_mag_g = thr;
    repeat (2) @(negedge clk);
    `CHK(drive_clk_en_r, 1'b0)
    send(2'h0, V, 4);
    wait_words(1);
    `CHK(last_w, {2'h0, V - (V >>> 3)})
    `CHK(group_delay_r, 32'h00000004)
    accel_mag_g = 8'h00;
    repeat (HOLD - 3) @(negedge clk);
    `CHK(drive_clk_en_r, 1'b0)
    repeat (5) @(negedge clk);
    `CHK(drive_clk_en_r, 1'b1)
  endtask
  task automatic t_sync;
    wr(10'h028, 8'h01);
    send(2'h1, 20'h00400, 4);
    wait_words(1);
    // Sync between second-stage halves moves the output tick by one sample
    ext_sync = 1'b1;
    @(negedge clk);
    ext_sync = 1'b0;
    send(2'h1, 20'h00400, 8);
    wait_words(2);
    `CHK(last_w, {2'h1, 20'hFF000})
    wr(10'h028, 8'h00);
  endtask
  task automatic t_selftest;
    logic [19:0] base;
    @(negedge clk);
    wr(10'h02E, 8'h01);
    send(2'h2, V, 8);
    wait_words(2);
    base = last_w[19:0];
    wr(10'h02E, 8'h03);
    `CHK(self_test_stim_r, 1'b1)
    // Front end answers the stimulus with a fixed shift of the z reading
    send(2'h2, V + 20'h00100, 8);
    wait_words(2);
    `CHK(last_w[19:0] - base, 20'h00100)
    wr(10'h02E, 8'h00);
    `CHK(self_test_stim_r, 1'b0)
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_regs();
    t_stream();
    t_hpf();
    t_odr();
    t_ovr(2'h0, 8'h28);
    t_ovr(2'h1, 8'h50);
    t_sync();
    t_selftest();
    print_verdict();
  end
endmodule
bind aspc_signal_path aspc_signal_path_asserts #(.OVR_HOLD_CYC(OVR_HOLD_CYC)) aspc_signal_path_asserts_inst (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .adc_ready_r(adc_ready_r), .range_sel(range_sel),
  .accel_mag_g(accel_mag_g), .drive_clk_en_r(drive_clk_en_r), .self_test_stim_r(self_test_stim_r),
  .smp_valid_r(smp_valid_r), .smp_ready(smp_ready), .smp_data_r(smp_data_r), .group_delay_r(group_delay_r));
`default_nettype wire
